// *** core/lbs_pkg.sv ***
// Constants, types and opcode decoding for the literal and branch sequencer.
// Assumes a 12-bit instruction word and a 9-bit program store address.
package lbs_pkg;

  // Datapath widths
  localparam int unsigned WORD_W      = 12;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PC_W        = 9;
  localparam int unsigned STACK_DEPTH = 2;
  localparam int unsigned SP_W        = 1;
  localparam int unsigned APB_AW      = 8;
  localparam int unsigned APB_DW      = 32;

  // Opcode fields
  localparam int unsigned OPC4_LSB   = 8;
  localparam int unsigned OPC3_LSB   = 9;
  localparam logic [3:0]  OPC_AND    = 4'he;
  localparam logic [3:0]  OPC_OR     = 4'hd;
  localparam logic [3:0]  OPC_MOV    = 4'hc;
  localparam logic [3:0]  OPC_CALL   = 4'h9;
  localparam logic [3:0]  OPC_RET    = 4'h8;
  localparam logic [2:0]  OPC_JUMP   = 3'h5;
  localparam logic [11:0] WDT_CLR_WORD = 12'h004;
  localparam logic [11:0] IR_RESET   = 12'h000;
  localparam logic [8:0]  PC_RESET   = 9'h000;

  // Program counter mux inputs
  localparam logic [1:0] PCSEL_STACK = 2'h0;
  localparam logic [1:0] PCSEL_CALL  = 2'h1;
  localparam logic [1:0] PCSEL_JUMP  = 2'h2;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PC      = 8'h08;
  localparam logic [7:0] ADDR_IR      = 8'h0c;
  localparam logic [7:0] ADDR_RETIRED = 8'h10;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_STEP_BIT    = 1;
  localparam int unsigned CTRL_RESTART_BIT = 2;
  localparam logic        CTRL_RUN_RESET   = 1'b1;
  localparam int unsigned STAT_ZERO_BIT    = 8;
  localparam int unsigned STAT_STATE_LSB   = 12;
  localparam int unsigned PCREG_SP_LSB     = 16;

  typedef enum logic [2:0] {
    ST_EXEC,
    ST_CALL2,
    ST_JUMP2,
    ST_RET2,
    ST_RET3
  } lbs_state_e;

  typedef enum logic [1:0] {
    ALU_PASS,
    ALU_AND,
    ALU_OR
  } lbs_alu_op_e;

  typedef enum logic [2:0] {
    OP_AND,
    OP_OR,
    OP_MOV,
    OP_CALL,
    OP_JUMP,
    OP_RET,
    OP_WDT,
    OP_OTHER
  } lbs_op_e;

  typedef struct packed {
    logic        fetch_latch_strobe;
    logic        counter_advance;
    logic        counter_load_strobe;
    logic [1:0]  pc_mux_sel;
    logic        stack_load;
    logic        stack_inc;
    logic        stack_dec;
    logic        acc_load;
    logic        zero_load;
    lbs_alu_op_e alu_op;
  } lbs_ctrl_s;

  function automatic lbs_op_e lbs_decode(input logic [WORD_W-1:0] word);
    lbs_op_e op;
    op = OP_OTHER;
    if (word == WDT_CLR_WORD) begin
      op = OP_WDT;
    end else if (word[WORD_W-1:OPC3_LSB] == OPC_JUMP) begin
      op = OP_JUMP;
    end else begin
      unique case (word[WORD_W-1:OPC4_LSB])
        OPC_AND:  op = OP_AND;
        OPC_OR:   op = OP_OR;
        OPC_MOV:  op = OP_MOV;
        OPC_CALL: op = OP_CALL;
        OPC_RET:  op = OP_RET;
        default:  op = OP_OTHER;
      endcase
    end
    return op;
  endfunction

endpackage

// *** core/lbs_alu.sv ***
// Literal ALU: accumulator combined with an eight-bit literal.
// Assumes the caller selects the literal source and the operation.
`timescale 1ns/10ps
module lbs_alu
  import lbs_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] i_acc,
  input  wire logic [DATA_W-1:0] i_literal,
  input  wire lbs_alu_op_e       i_op,
  // Result
  output logic      [DATA_W-1:0] o_result,
  output logic                   o_zero
);

  always_comb begin
    unique case (i_op)
      ALU_AND: o_result = i_acc & i_literal;
      ALU_OR:  o_result = i_acc | i_literal;
      default: o_result = i_literal;
    endcase
  end

  assign o_zero = (o_result == '0);

endmodule

// *** core/lbs_sequencer.sv ***
// Literal and branch instruction sequencer with its accumulator, zero flag,
// program counter, return stack and a small APB register window.
// Assumes an external program store answering in the same cycle.
`timescale 1ns/10ps
module lbs_sequencer
  import lbs_pkg::*;
(
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // APB slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [APB_AW-1:0] I_PADDR,
  input  wire logic [APB_DW-1:0] I_PWDATA,
  input  wire logic [3:0]        I_PSTRB,
  output logic      [APB_DW-1:0] O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // Program store
  output logic      [PC_W-1:0]   O_PROG_ADDR,
  input  wire logic [WORD_W-1:0] I_PROG_WORD,
  // Datapath observation
  output logic      [DATA_W-1:0] O_ACC,
  output logic                   O_ZERO,
  output lbs_ctrl_s              O_CTRL
);

  // Sequencer state and datapath registers
  lbs_state_e          state_reg;
  lbs_state_e          state_next;
  logic [WORD_W-1:0]   ir_reg;
  logic [PC_W-1:0]     pc_reg;
  logic [PC_W-1:0]     pc_next;
  logic [DATA_W-1:0]   acc_reg;
  logic                zero_reg;
  logic [PC_W-1:0]     stack_reg [STACK_DEPTH];
  logic [SP_W-1:0]     sp_reg;
  logic [DATA_W-1:0]   lit_hold_reg;
  logic                run_reg;
  logic                step_reg;
  logic [APB_DW-1:0]   retired_reg;
  logic [APB_DW-1:0]   prdata_reg;
  logic                pslverr_reg;
  // Decoded strobes and bus glue
  lbs_ctrl_s           ctrl;
  lbs_op_e             ir_op;
  logic                active;
  logic                use_hold;
  logic [DATA_W-1:0]   alu_literal;
  logic [DATA_W-1:0]   alu_result;
  logic                alu_zero;
  logic                apb_setup;
  logic                apb_write;
  logic                wr_ctrl;
  logic                restart;
  logic                step_taken;
  logic [APB_DW-1:0]   read_data;

  function automatic logic addr_mapped(input logic [APB_AW-1:0] addr);
    return (addr == ADDR_CTRL) || (addr == ADDR_STATUS) || (addr == ADDR_PC) ||
           (addr == ADDR_IR) || (addr == ADDR_RETIRED);
  endfunction

  assign ir_op  = lbs_decode(ir_reg);
  // Halting only takes effect at an instruction boundary
  assign active = (state_reg != ST_EXEC) || run_reg || step_reg;
  assign step_taken = (state_reg == ST_EXEC) && !run_reg && step_reg;

  // Control strobes and sequencing
  always_comb begin
    ctrl            = '0;
    ctrl.pc_mux_sel = PCSEL_STACK;
    ctrl.alu_op     = ALU_PASS;
    use_hold        = 1'b0;
    state_next      = state_reg;
    // No strobes at all while halted between instructions
    if (active) begin
      unique case (state_reg)
        ST_EXEC: begin
          ctrl.fetch_latch_strobe = 1'b1;
          ctrl.counter_advance    = 1'b1;
          unique case (ir_op)
            OP_AND: begin
              ctrl.alu_op    = ALU_AND;
              ctrl.acc_load  = 1'b1;
              ctrl.zero_load = 1'b1;
            end
            OP_OR: begin
              ctrl.alu_op    = ALU_OR;
              ctrl.acc_load  = 1'b1;
              ctrl.zero_load = 1'b1;
            end
            OP_MOV: begin
              ctrl.alu_op   = ALU_PASS;
              ctrl.acc_load = 1'b1;
            end
            OP_CALL: begin
              ctrl.pc_mux_sel          = PCSEL_CALL;
              ctrl.counter_load_strobe = 1'b1;
              ctrl.stack_load          = 1'b1;
              state_next               = ST_CALL2;
            end
            OP_JUMP: begin
              ctrl.pc_mux_sel          = PCSEL_JUMP;
              ctrl.counter_load_strobe = 1'b1;
              state_next               = ST_JUMP2;
            end
            OP_RET: begin
              ctrl.stack_dec = 1'b1;
              state_next     = ST_RET2;
            end
            OP_WDT: begin
              state_next = ST_EXEC;
            end
            OP_OTHER: begin
              state_next = ST_EXEC;
            end
          endcase
        end
        ST_CALL2: begin
          ctrl.stack_inc          = 1'b1;
          ctrl.fetch_latch_strobe = 1'b1;
          ctrl.counter_advance    = 1'b1;
          state_next              = ST_EXEC;
        end
        ST_JUMP2: begin
          ctrl.fetch_latch_strobe = 1'b1;
          ctrl.counter_advance    = 1'b1;
          state_next              = ST_EXEC;
        end
        ST_RET2: begin
          ctrl.pc_mux_sel          = PCSEL_STACK;
          ctrl.counter_load_strobe = 1'b1;
          state_next               = ST_RET3;
        end
        ST_RET3: begin
          ctrl.fetch_latch_strobe = 1'b1;
          ctrl.counter_advance    = 1'b1;
          ctrl.acc_load           = 1'b1;
          use_hold                = 1'b1;
          state_next              = ST_EXEC;
        end
        default: begin
          state_next = ST_EXEC;
        end
      endcase
    end
  end

  // The return literal is gone from the word latch once cycle one fetches
  assign alu_literal = use_hold ? lit_hold_reg : ir_reg[DATA_W-1:0];

  // Shared by logic ops, literal move, call target and return literal
  lbs_alu u_alu (
    .i_acc     (acc_reg),
    .i_literal (alu_literal),
    .i_op      (ctrl.alu_op),
    .o_result  (alu_result),
    .o_zero    (alu_zero)
  );

  // State register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_EXEC;
    end else if (restart) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction latch
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ir_reg <= IR_RESET;
    end else if (restart) begin
      ir_reg <= IR_RESET;
    end else if (ctrl.fetch_latch_strobe) begin
      ir_reg <= I_PROG_WORD;
    end
  end

  // Program counter: load beats advance
  always_comb begin
    pc_next = pc_reg;
    if (ctrl.counter_load_strobe) begin
      unique case (ctrl.pc_mux_sel)
        PCSEL_CALL:  pc_next = {pc_reg[PC_W-1], alu_result};
        PCSEL_JUMP:  pc_next = ir_reg[PC_W-1:0];
        default:     pc_next = {pc_reg[PC_W-1], stack_reg[sp_reg][DATA_W-1:0]};
      endcase
    end else if (ctrl.counter_advance) begin
      pc_next = PC_W'(pc_reg + 1'b1);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pc_reg <= PC_RESET;
    end else if (restart) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Accumulator and zero flag
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      acc_reg <= '0;
    end else if (ctrl.acc_load) begin
      acc_reg <= alu_result;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      zero_reg <= 1'b0;
    end else if (ctrl.zero_load) begin
      zero_reg <= alu_zero;
    end
  end

  // Return stack slots
  // A push writes the slot the pointer names; the pointer moves next cycle
  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          stack_reg[gi] <= PC_RESET;
        end else if (ctrl.stack_load && (sp_reg == SP_W'(gi))) begin
          stack_reg[gi] <= pc_reg;
        end
      end
    end
  endgenerate

  // Stack pointer wraps over the slots
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sp_reg <= '0;
    end else if (restart) begin
      sp_reg <= '0;
    end else if (ctrl.stack_inc) begin
      sp_reg <= SP_W'(sp_reg + 1'b1);
    end else if (ctrl.stack_dec) begin
      sp_reg <= SP_W'(sp_reg - 1'b1);
    end
  end

  // Return literal kept for the third return cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lit_hold_reg <= '0;
    end else if (ctrl.stack_dec) begin
      lit_hold_reg <= ir_reg[DATA_W-1:0];
    end
  end

  // Retired instruction count
  // Only the fetch that closes an instruction counts
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      retired_reg <= '0;
    end else if (restart) begin
      retired_reg <= '0;
    end else if (ctrl.fetch_latch_strobe && (state_next == ST_EXEC)) begin
      retired_reg <= APB_DW'(retired_reg + 1'b1);
    end
  end

  // APB slave, zero wait states
  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_write = I_PSEL && I_PENABLE && I_PWRITE;
  assign wr_ctrl   = apb_write && (I_PADDR == ADDR_CTRL) && I_PSTRB[0];
  assign restart   = wr_ctrl && I_PWDATA[CTRL_RESTART_BIT];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      run_reg <= CTRL_RUN_RESET;
    end else if (wr_ctrl) begin
      run_reg <= I_PWDATA[CTRL_RUN_BIT];
    end
  end

  // Software request wins over consumption in the same cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      step_reg <= 1'b0;
    end else if (wr_ctrl && I_PWDATA[CTRL_STEP_BIT]) begin
      step_reg <= 1'b1;
    end else if (step_taken) begin
      step_reg <= 1'b0;
    end
  end

  // Register read decode; unused bits read as zero
  always_comb begin
    read_data = '0;
    unique case (I_PADDR)
      ADDR_CTRL: begin
        read_data[CTRL_RUN_BIT]  = run_reg;
        read_data[CTRL_STEP_BIT] = step_reg;
      end
      ADDR_STATUS: begin
        read_data[DATA_W-1:0]                     = acc_reg;
        read_data[STAT_ZERO_BIT]                  = zero_reg;
        read_data[STAT_STATE_LSB +: $bits(state_reg)] = state_reg;
      end
      ADDR_PC: begin
        read_data[PC_W-1:0]               = pc_reg;
        read_data[PCREG_SP_LSB +: SP_W]   = sp_reg;
      end
      ADDR_IR:      read_data[WORD_W-1:0] = ir_reg;
      ADDR_RETIRED: read_data = retired_reg;
      default:      read_data = '0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= I_PWRITE ? '0 : read_data;
      pslverr_reg <= !addr_mapped(I_PADDR) || (I_PWRITE && (I_PADDR != ADDR_CTRL));
    end
  end

  // Port drives
  assign O_PRDATA    = prdata_reg;
  assign O_PREADY    = 1'b1;
  assign O_PSLVERR   = pslverr_reg && I_PSEL && I_PENABLE;
  assign O_PROG_ADDR = pc_reg;
  assign O_ACC       = acc_reg;
  assign O_ZERO      = zero_reg;
  assign O_CTRL      = ctrl;

endmodule

// *** verification/lbs_seq_monitor.sv ***
// Concurrent checks on the sequencer ports.
// Assumes binding onto every lbs_sequencer instance.
`timescale 1ns/10ps
module lbs_seq_monitor
  import lbs_pkg::*;
(
  // Clock and reset
  input wire logic              I_CLK,
  input wire logic              I_RST,
  // APB
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [APB_AW-1:0] I_PADDR,
  input wire logic [APB_DW-1:0] I_PWDATA,
  input wire logic [3:0]        I_PSTRB,
  input wire logic [APB_DW-1:0] O_PRDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  // Program store and datapath
  input wire logic [PC_W-1:0]   O_PROG_ADDR,
  input wire logic [WORD_W-1:0] I_PROG_WORD,
  input wire logic [DATA_W-1:0] O_ACC,
  input wire logic              O_ZERO,
  input wire lbs_ctrl_s         O_CTRL
);
  logic armed_reg;

  // Outputs at the edge that releases reset still show the reset state
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  default clocking mon_cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST || !armed_reg);

  logic call_go;
  logic jump_go;
  assign call_go = O_CTRL.counter_load_strobe && O_CTRL.pc_mux_sel == PCSEL_CALL;
  assign jump_go = O_CTRL.counter_load_strobe && O_CTRL.pc_mux_sel == PCSEL_JUMP;

  sequence call_tail;
    O_CTRL.stack_inc && !O_CTRL.counter_load_strobe && !O_CTRL.stack_load;
  endsequence
  sequence jump_tail;
    O_CTRL.fetch_latch_strobe && !O_CTRL.counter_load_strobe;
  endsequence

  chk_call_steps: assert property (call_go |-> O_CTRL.stack_load
    && O_CTRL.fetch_latch_strobe ##1 call_tail) else $error("call sequence wrong");
  chk_call_high: assert property (call_go |=> O_PROG_ADDR[8] == $past(O_PROG_ADDR[8]))
    else $error("call changed counter bit 8");
  chk_jump_steps: assert property (jump_go |-> O_CTRL.fetch_latch_strobe ##1 jump_tail)
    else $error("jump sequence wrong");
  chk_pc_step: assert property (O_CTRL.fetch_latch_strobe && O_CTRL.counter_advance
    && !O_CTRL.counter_load_strobe |=> O_PROG_ADDR == $past(O_PROG_ADDR) + 9'h001)
    else $error("counter did not advance");
  chk_logic_pair: assert property (O_CTRL.acc_load && O_CTRL.alu_op != ALU_PASS
    |-> O_CTRL.zero_load) else $error("logic op without zero load");
  chk_zero_src: assert property (O_CTRL.zero_load |-> O_CTRL.acc_load
    && O_CTRL.alu_op != ALU_PASS) else $error("zero load outside logic op");
  chk_zero_value: assert property (O_CTRL.zero_load |=> O_ZERO == (O_ACC == 8'h00))
    else $error("zero flag wrong");
  chk_flag_hold: assert property (!O_CTRL.zero_load |=> $stable(O_ZERO))
    else $error("zero flag changed");
  chk_acc_hold: assert property (!O_CTRL.acc_load |=> $stable(O_ACC))
    else $error("accumulator changed");

  sequence ret_reload;
    O_CTRL.counter_load_strobe && O_CTRL.pc_mux_sel == PCSEL_STACK
      && !O_CTRL.fetch_latch_strobe;
  endsequence
  sequence ret_finish;
    O_CTRL.fetch_latch_strobe && O_CTRL.acc_load && !O_CTRL.zero_load;
  endsequence

  chk_ret_steps: assert property (O_CTRL.stack_dec |-> O_CTRL.fetch_latch_strobe
    ##1 ret_reload ##1 ret_finish) else $error("return sequence wrong");
endmodule

bind lbs_sequencer lbs_seq_monitor lbs_seq_monitor_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_PROG_ADDR(O_PROG_ADDR), .I_PROG_WORD(I_PROG_WORD),
  .O_ACC(O_ACC), .O_ZERO(O_ZERO), .O_CTRL(O_CTRL));

// *** verification/lbs_prog_store.sv ***
// Program store model, answers in the same cycle.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module lbs_prog_store
  import lbs_pkg::*;
(
  // Address in, word out
  input  wire logic [PC_W-1:0]   i_addr,
  output logic      [WORD_W-1:0] o_word
);
  logic [WORD_W-1:0] mem [0:(1<<PC_W)-1];
  assign o_word = mem[i_addr];
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the sequencer against an instruction model.
// Assumes the program store model and the bound monitor.
`timescale 1ns/10ps
module tb_top;
  import lbs_pkg::*;
  logic              clk, rst, psel, pen, pwr, pready, pslverr, zero, ld, er;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic [PC_W-1:0]   prog_addr;
  logic [WORD_W-1:0] prog_word;
  logic [DATA_W-1:0] acc;
  lbs_ctrl_s         ctrl;
  int                err_total, tests_run, seed, fin;
  int                exp_q[$];

  lbs_sequencer lbs_sequencer_i (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PROG_ADDR(prog_addr), .I_PROG_WORD(prog_word), .O_ACC(acc), .O_ZERO(zero),
    .O_CTRL(ctrl));
  lbs_prog_store lbs_prog_store_i (.i_addr(prog_addr), .o_word(prog_word));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic put(input int a, input logic [3:0] op, input logic [7:0] k);
    lbs_prog_store_i.mem[a] = {op, k};
  endtask

  // Instruction model: pushes {zero, acc} after every accumulator load
  task automatic model;
    int pc, a, z, w, op;
    int stk[$];
    pc = 0;
    a = fin % 256;
    z = fin / 256;
    for (int n = 0; n < 100; n++) begin
      w = lbs_prog_store_i.mem[pc];
      op = w >> 8;
      if (op == 14) a = a & (w & 255);
      if (op == 13) a = a | (w & 255);
      if (op == 12 || op == 8) a = w & 255;
      if (op == 13 || op == 14) z = (a == 0);
      if (op inside {8, 12, 13, 14}) exp_q.push_back(a + 256 * z);
      if (op == 9) begin
        stk.push_back(pc + 1);
        pc = (w & 255) - 1;
      end
      if (op == 8) pc = stk.pop_back() - 1;
      if (op == 10 || op == 11) begin
        if ((w & 511) == pc) break;
        pc = (w & 511) - 1;
      end
      pc++;
    end
    fin = a + 256 * z;
  endtask

  always @(negedge clk) begin
    if (ld) chk("acc_zero", {23'h0, zero, acc}, exp_q.size() ? exp_q.pop_front() : -1);
    ld = ctrl.acc_load;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100us;
    err_total++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    ld = 1'b0;
    {psel, pen, pwr, paddr, pwdata} = '0;
    pstrb = 4'hf;
    seed = 22;
    for (int i = 0; i < (1 << PC_W); i++) lbs_prog_store_i.mem[i] = '0;
    put(0, OPC_MOV, 8'($random(seed)));
    for (int i = 1; i < 9; i++) begin
      put(i, 4'hc + 4'($unsigned($random(seed)) % 3), 8'($random(seed)));
    end
    put(4, OPC_AND, 8'h00);
    lbs_prog_store_i.mem[9] = WDT_CLR_WORD;
    put(10, OPC_CALL, 8'h80);
    put(11, OPC_AND, 8'($random(seed)));
    lbs_prog_store_i.mem[12] = 12'hba0;
    put(128, OPC_OR, 8'($random(seed)));
    put(129, OPC_RET, 8'($random(seed)));
    put(416, OPC_MOV, 8'($random(seed)));
    lbs_prog_store_i.mem[417] = 12'hba1;
    model();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h1);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("queue_left", exp_q.size(), 0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd & 32'h1ff, fin);
    apb(1'b0, ADDR_PC, 32'h0);
    chk("pc_high", {31'h0, rd[8]}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h5a);
    chk("ro_write", {31'h0, er}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("strobe_off", rd, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("halted", {31'h0, ctrl.fetch_latch_strobe}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_kept", rd & 32'h1ff, fin);
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b0, ADDR_PC, 32'h0);
    chk("restart_pc", rd, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, ADDR_PC, 32'h0);
    chk("step_pc", rd, 32'h1);
    apb(1'b0, ADDR_IR, 32'h0);
    chk("step_ir", rd, {20'h0, lbs_prog_store_i.mem[0]});
    apb(1'b0, ADDR_RETIRED, 32'h0);
    chk("step_count", rd, 32'h1);
    model();
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("queue_again", exp_q.size(), 0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_again", rd & 32'h1ff, fin);
    end_of_test();
  end
endmodule
